// file: sgec_defines.svh
/*
  Constants of the gain, exposure and readout control block: register
  indices, reset values, field positions and timing figures.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SGEC_DEFINES_SVH
`define SGEC_DEFINES_SVH

// Register indices; byte address is four times the index
`define SGEC_IDX_FRAME_LINES  14'h3024
`define SGEC_IDX_DIRECTION    14'h3030
`define SGEC_IDX_SWEEP_LINE   14'h3050
`define SGEC_IDX_GAIN_CODE    14'h3090
`define SGEC_IDX_BLACK_LEVEL  14'h30E2
`define SGEC_IDX_SYNC_ROLE    14'h3003
`define SGEC_IDX_CONV_WIDTH   14'h3031
`define SGEC_IDX_STATUS       14'h3100
`define SGEC_IDX_INTEG_LINES  14'h3101

// Reset values
`define SGEC_RST_FRAME_LINES  20'h008CA
`define SGEC_RST_DIRECTION    2'h0
`define SGEC_RST_SWEEP_LINE   20'h00066
`define SGEC_RST_GAIN_CODE    9'h000
`define SGEC_RST_BLACK_LEVEL  10'h032
`define SGEC_RST_SYNC_ROLE    1'h0
`define SGEC_RST_CONV_WIDTH   1'h1

// Field positions
`define SGEC_BIT_HFLIP        0
`define SGEC_BIT_VFLIP        1

// Gain code limits and step count per 6 dB (one doubling)
`define SGEC_GAIN_MAX         9'h0F0
`define SGEC_GAIN_OCTAVE      9'h014

// Output full scale per conversion width
`define SGEC_MAX_10BIT        12'h3FF
`define SGEC_MAX_12BIT        12'hFFF

// Timing figures
`define SGEC_CLK_MHZ          50
`define SGEC_TOFF10_NS        1790
`define SGEC_TOFF12_NS        2680

// Bus answers
`define SGEC_RESP_OKAY        2'h0
`define SGEC_RESP_SLVERR      2'h2

`endif

// file: sgec_pkg.sv
/*
  Types of the gain, exposure and readout control block: bus carriers.
  Assumes nothing of its surroundings.
*/
package sgec_pkg;

  typedef struct packed {
    logic        awvalid;
    logic [15:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [15:0] araddr;
    logic        rready;
  } sgec_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sgec_axi_rsp_s;

endpackage : sgec_pkg

// file: sgec_pixel_gain.sv
/*
  Pixel level path: applies the total gain code, then adds the black
  level offset, and clamps to the selected output full scale.
  Assumes gain, offset and width are stable across a frame.
*/
`timescale 1ns/10ps
`include "sgec_defines.svh"

module sgec_pixel_gain (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        pix_valid_i,
  input  wire logic [11:0] pix_data_i,
  input  wire logic [8:0]  gain_code_i,
  input  wire logic [9:0]  black_level_i,
  input  wire logic        wide_i,
  output logic             pix_valid_o,
  output logic [11:0]      pix_data_o
);

  // Clamp to the full scale of the output width
  function automatic logic [11:0] sat(input logic [33:0] v, input logic wide);
    logic [11:0] top;
    top = wide ? `SGEC_MAX_12BIT : `SGEC_MAX_10BIT;
    sat = (v > {22'h0, top}) ? top : v[11:0];
  endfunction : sat

  // Fraction of a doubling, 2^(k/20) in Q8
  function automatic logic [8:0] frac_q8(input logic [8:0] k);
    case (k)
      9'h000: frac_q8 = 9'h100;
      9'h001: frac_q8 = 9'h109;
      9'h002: frac_q8 = 9'h112;
      9'h003: frac_q8 = 9'h11C;
      9'h004: frac_q8 = 9'h126;
      9'h005: frac_q8 = 9'h130;
      9'h006: frac_q8 = 9'h13B;
      9'h007: frac_q8 = 9'h146;
      9'h008: frac_q8 = 9'h152;
      9'h009: frac_q8 = 9'h15D;
      9'h00A: frac_q8 = 9'h16A;
      9'h00B: frac_q8 = 9'h176;
      9'h00C: frac_q8 = 9'h184;
      9'h00D: frac_q8 = 9'h191;
      9'h00E: frac_q8 = 9'h1A0;
      9'h00F: frac_q8 = 9'h1AE;
      9'h010: frac_q8 = 9'h1BE;
      9'h011: frac_q8 = 9'h1CD;
      9'h012: frac_q8 = 9'h1DE;
      default: frac_q8 = 9'h1EE;
    endcase
  endfunction : frac_q8

  logic [8:0]  code;
  logic [33:0] gained;
  logic [11:0] offset;
  logic [11:0] next_data;
  logic        next_valid;

  always_comb begin
    // Codes above the top of the range saturate at 72 dB
    code = (gain_code_i > `SGEC_GAIN_MAX) ? `SGEC_GAIN_MAX : gain_code_i; // [RULE1] [RULE2]
    gained = (({13'h0, pix_data_i, 9'h0} >> 9) * {25'h0, frac_q8(code % `SGEC_GAIN_OCTAVE)}
              << (code / `SGEC_GAIN_OCTAVE)) >> 8; // [RULE1]
    offset = wide_i ? {black_level_i, 2'h0} : {2'h0, black_level_i}; // [RULE5]
    next_data = sat({22'h0, sat(gained, wide_i)} + {22'h0, offset}, wide_i); // [RULE4]
    next_valid = pix_valid_i;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pix_valid_o <= 1'b0;
      pix_data_o  <= 12'h000;
    end else begin
      pix_valid_o <= next_valid;
      pix_data_o  <= next_data;
    end
  end

endmodule : sgec_pixel_gain

// file: sgec_top.sv
/*
  Gain, exposure and readout control of a rolling shutter image sensor:
  AXI4-Lite register file with frame-boundary shadowing, frame and line
  timing from external syncs or the internal line counter, rolling
  shutter and readout row sequencing, and the pixel level path.
  Assumes sync pins are asynchronous and active low; pixels arrive on
  clock_i; one AXI write and one read at most are under way.
*/
`timescale 1ns/10ps
`include "sgec_defines.svh"

// Summary of operation
// [RULE1] Gain code is dB times ten thirds, 0.3 dB steps, codes 0 to 240.
// [RULE2] Total gain reaches 72 dB at most, one code for all colours.
// [RULE3] New gain takes effect from the frame after the write.
// [RULE4] Ten-bit black level offset is added after digital gain.
// [RULE5] One offset unit is 1 code at 10 bits, 4 codes at 12 bits.
// [RULE6] Host should program black level 0x32 in both widths.
// [RULE7] Direction bit 0 flips horizontally, bit 1 vertically; one inverts.
// [RULE8] First frame after a vertical direction change is flagged invalid.
// [RULE9] Rolling shutter: reset and readout line by line, whole-line exposure.
// [RULE10] New integration time appears from the next frame's image.
// [RULE11] Integration is frame minus sweep line lines, plus 1.79 or 2.68 us.
// [RULE12] Frame length follows external vsync in slave, register in master.
// [RULE13] Host keeps sweep line between 8 and frame lines minus 4.
// [RULE14] Slave counts lines as hsync intervals between vsync pulses.
// [RULE15] Longer frames extend rear vertical blanking by the same lines.
// [RULE16] Host should keep long exposure near one second at most.
// [RULE17] Frame line count register applies only in master mode.
// [RULE18] Host fixes master or slave role before reset release.
// [RULE19] Conversion width bit picks 10 or 12 bits and the time offset.
// [RULE20] Gain, black level and sweep line are shadowed until frame start.
module sgec_top #(
  parameter int unsigned LINE_CYCLES = 1100,
  parameter int unsigned READ_LINES  = 2176
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_b_i,
  input  wire sgec_pkg::sgec_axi_req_s axi_req_i,
  output sgec_pkg::sgec_axi_rsp_s     axi_rsp_o,
  input  wire logic                   vert_sync_pin_b_i,
  input  wire logic                   horiz_sync_pin_b_i,
  input  wire logic                   pix_valid_i,
  input  wire logic [11:0]            pix_data_i,
  output logic                        pix_valid_o,
  output logic [11:0]                 pix_data_o,
  output logic                        frame_start_o,
  output logic                        line_tick_o,
  output logic                        readout_en_o,
  output logic [19:0]                 readout_row_o,
  output logic                        shutter_en_o,
  output logic [19:0]                 shutter_row_o,
  output logic                        horiz_flip_o,
  output logic                        vert_flip_o,
  output logic                        frame_invalid_o,
  output logic [19:0]                 integ_lines_o,
  output logic [7:0]                  integ_offset_o
);

  localparam logic [7:0] TOFF10_CYC =
    8'((`SGEC_TOFF10_NS * `SGEC_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] TOFF12_CYC =
    8'((`SGEC_TOFF12_NS * `SGEC_CLK_MHZ + 999) / 1000);
  localparam logic [15:0] LINE_LAST = 16'(LINE_CYCLES - 1);
  localparam logic [19:0] READ_N    = 20'(READ_LINES);

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
    end
  endfunction : merge

  // Row address as seen through the vertical flip
  function automatic logic [19:0] row_map(input logic [19:0] r, input logic flip);
    row_map = flip ? (READ_N - 20'h1 - r) : r;
  endfunction : row_map

  // Shadow registers written by software
  logic [19:0] frame_line_count, shutter_sweep_line;
  logic [1:0]  readout_direction_ctrl;
  logic [8:0]  total_gain_code;
  logic [9:0]  black_level_offset;
  logic        sync_role_select, conversion_width_select;
  // Active copies used by the frame in flight
  logic [8:0]  act_gain;
  logic [9:0]  act_black;
  logic [19:0] act_sweep;
  logic        act_wide;
  // Timing state
  logic        vs_s1, vs_s2, vs_d, hs_s1, hs_s2, hs_d;
  logic [15:0] hcnt;
  logic [19:0] line_cnt, meas_lines;
  // Bus state
  logic        aw_held, w_held;
  logic [13:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  logic [19:0] next_frame_line_count, next_shutter_sweep_line;
  logic [1:0]  next_readout_direction_ctrl;
  logic [8:0]  next_total_gain_code, next_act_gain;
  logic [9:0]  next_black_level_offset, next_act_black;
  logic        next_sync_role_select, next_conversion_width_select;
  logic [19:0] next_act_sweep, next_line_cnt, next_meas_lines;
  logic        next_act_wide;
  logic [15:0] next_hcnt;
  logic        next_aw_held, next_w_held;
  logic [13:0] next_aw_idx;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  sgec_pkg::sgec_axi_rsp_s next_rsp;
  logic        next_frame_start, next_line_tick, next_readout_en, next_shutter_en;
  logic [19:0] next_readout_row, next_shutter_row, next_integ_lines;
  logic        next_hflip, next_vflip, next_invalid;
  logic [7:0]  next_integ_offset;

  logic        line_tick, frame_tick, hit, ok;
  logic [19:0] flen, frame_lines, sdiff;
  logic [31:0] img, rd;

  always_comb begin
    // Line and frame events from the chosen sync source
    flen = (frame_line_count == 20'h0) ? 20'h1 : frame_line_count;
    if (sync_role_select) begin
      line_tick  = hs_d && !hs_s2;
      frame_tick = vs_d && !vs_s2; // [RULE12] [RULE14]
    end else begin
      line_tick  = (hcnt == LINE_LAST);
      frame_tick = line_tick && (line_cnt + 20'h1 >= flen); // [RULE12] [RULE17]
    end
    next_hcnt = (sync_role_select || line_tick) ? 16'h0 : hcnt + 16'h1;
    next_meas_lines = (sync_role_select && frame_tick) ? line_cnt : meas_lines; // [RULE14]
    if (frame_tick) begin
      next_line_cnt = 20'h0;
    end else if (line_tick) begin
      next_line_cnt = line_cnt + 20'h1;
    end else begin
      next_line_cnt = line_cnt;
    end
    frame_lines = sync_role_select ? next_meas_lines : flen;

    // Frame start moves shadows into the active set
    next_act_gain  = frame_tick ? total_gain_code : act_gain; // [RULE3] [RULE20]
    next_act_black = frame_tick ? black_level_offset : act_black; // [RULE20]
    next_act_sweep = frame_tick ? shutter_sweep_line : act_sweep; // [RULE10] [RULE20]
    next_act_wide  = frame_tick ? conversion_width_select : act_wide;
    next_hflip = frame_tick ? readout_direction_ctrl[`SGEC_BIT_HFLIP] : horiz_flip_o; // [RULE7]
    next_vflip = frame_tick ? readout_direction_ctrl[`SGEC_BIT_VFLIP] : vert_flip_o; // [RULE7]
    next_invalid = frame_tick ?
      (readout_direction_ctrl[`SGEC_BIT_VFLIP] != vert_flip_o) : frame_invalid_o; // [RULE8]
    next_integ_lines = frame_tick ?
      ((frame_lines > shutter_sweep_line) ? frame_lines - shutter_sweep_line : 20'h0)
      : integ_lines_o; // [RULE11]
    next_integ_offset = conversion_width_select ? TOFF12_CYC : TOFF10_CYC; // [RULE11] [RULE19]

    // Rolling shutter: line n resets row n minus sweep, reads row n
    next_frame_start = frame_tick;
    next_line_tick   = line_tick;
    next_readout_en  = line_tick && (next_line_cnt < READ_N); // [RULE9] [RULE15]
    next_readout_row = line_tick ? row_map(next_line_cnt, next_vflip) : readout_row_o; // [RULE9]
    sdiff = next_line_cnt - next_act_sweep;
    next_shutter_en  = line_tick && (next_line_cnt >= next_act_sweep) && (sdiff < READ_N); // [RULE9]
    next_shutter_row = next_shutter_en ? row_map(sdiff, next_vflip) : shutter_row_o; // [RULE10]

    // Write channel capture, address and data in either order
    next_rsp = axi_rsp_o;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_idx  = aw_idx;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_frame_line_count        = frame_line_count;
    next_shutter_sweep_line      = shutter_sweep_line;
    next_readout_direction_ctrl  = readout_direction_ctrl;
    next_total_gain_code         = total_gain_code;
    next_black_level_offset      = black_level_offset;
    next_sync_role_select        = sync_role_select;
    next_conversion_width_select = conversion_width_select;
    if (axi_req_i.awvalid && axi_rsp_o.awready) begin
      next_aw_held = 1'b1;
      next_aw_idx  = axi_req_i.awaddr[15:2];
    end
    if (axi_req_i.wvalid && axi_rsp_o.wready) begin
      next_w_held = 1'b1;
      next_w_data = axi_req_i.wdata;
      next_w_strb = axi_req_i.wstrb;
    end
    if (axi_rsp_o.bvalid && axi_req_i.bready) begin
      next_rsp.bvalid = 1'b0;
    end
    hit = 1'b0;
    if (aw_held && w_held && !axi_rsp_o.bvalid) begin
      hit = 1'b1;
      case (aw_idx)
        `SGEC_IDX_FRAME_LINES: begin
          img = merge({12'h0, frame_line_count}, w_data, w_strb);
          next_frame_line_count = img[19:0];
        end
        `SGEC_IDX_DIRECTION: begin
          img = merge({30'h0, readout_direction_ctrl}, w_data, w_strb);
          next_readout_direction_ctrl = img[1:0];
        end
        `SGEC_IDX_SWEEP_LINE: begin
          img = merge({12'h0, shutter_sweep_line}, w_data, w_strb);
          next_shutter_sweep_line = img[19:0];
        end
        `SGEC_IDX_GAIN_CODE: begin
          img = merge({23'h0, total_gain_code}, w_data, w_strb);
          next_total_gain_code = img[8:0];
        end
        `SGEC_IDX_BLACK_LEVEL: begin
          img = merge({22'h0, black_level_offset}, w_data, w_strb);
          next_black_level_offset = img[9:0];
        end
        `SGEC_IDX_SYNC_ROLE: begin
          img = merge({31'h0, sync_role_select}, w_data, w_strb);
          next_sync_role_select = img[0];
        end
        `SGEC_IDX_CONV_WIDTH: begin
          img = merge({31'h0, conversion_width_select}, w_data, w_strb);
          next_conversion_width_select = img[0];
        end
        default: begin
          img = 32'h0;
          hit = 1'b0;
        end
      endcase
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_rsp.bvalid = 1'b1;
      next_rsp.bresp  = hit ? `SGEC_RESP_OKAY : `SGEC_RESP_SLVERR;
    end else begin
      img = 32'h0;
    end
    next_rsp.awready = !next_aw_held && !next_rsp.bvalid;
    next_rsp.wready  = !next_w_held && !next_rsp.bvalid;

    // Read channel: one cycle from address to data
    ok = 1'b1;
    case (axi_req_i.araddr[15:2])
      `SGEC_IDX_FRAME_LINES: rd = {12'h0, frame_line_count};
      `SGEC_IDX_DIRECTION:   rd = {30'h0, readout_direction_ctrl};
      `SGEC_IDX_SWEEP_LINE:  rd = {12'h0, shutter_sweep_line};
      `SGEC_IDX_GAIN_CODE:   rd = {23'h0, total_gain_code};
      `SGEC_IDX_BLACK_LEVEL: rd = {22'h0, black_level_offset};
      `SGEC_IDX_SYNC_ROLE:   rd = {31'h0, sync_role_select};
      `SGEC_IDX_CONV_WIDTH:  rd = {31'h0, conversion_width_select};
      `SGEC_IDX_STATUS:      rd = {11'h0, frame_invalid_o, meas_lines};
      `SGEC_IDX_INTEG_LINES: rd = {12'h0, integ_lines_o};
      default: begin
        rd = 32'h0;
        ok = 1'b0;
      end
    endcase
    if (axi_rsp_o.rvalid && axi_req_i.rready) begin
      next_rsp.rvalid = 1'b0;
    end
    if (axi_req_i.arvalid && axi_rsp_o.arready) begin
      next_rsp.rvalid = 1'b1;
      next_rsp.rdata  = rd;
      next_rsp.rresp  = ok ? `SGEC_RESP_OKAY : `SGEC_RESP_SLVERR;
    end
    next_rsp.arready = !next_rsp.rvalid && !(axi_req_i.arvalid && axi_rsp_o.arready);
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame_line_count        <= `SGEC_RST_FRAME_LINES;
      shutter_sweep_line      <= `SGEC_RST_SWEEP_LINE;
      readout_direction_ctrl  <= `SGEC_RST_DIRECTION;
      total_gain_code         <= `SGEC_RST_GAIN_CODE;
      black_level_offset      <= `SGEC_RST_BLACK_LEVEL;
      sync_role_select        <= `SGEC_RST_SYNC_ROLE;
      conversion_width_select <= `SGEC_RST_CONV_WIDTH;
      act_gain   <= `SGEC_RST_GAIN_CODE;
      act_black  <= `SGEC_RST_BLACK_LEVEL;
      act_sweep  <= `SGEC_RST_SWEEP_LINE;
      act_wide   <= `SGEC_RST_CONV_WIDTH;
      vs_s1 <= 1'b1;
      vs_s2 <= 1'b1;
      vs_d  <= 1'b1;
      hs_s1 <= 1'b1;
      hs_s2 <= 1'b1;
      hs_d  <= 1'b1;
      hcnt       <= 16'h0;
      line_cnt   <= 20'h0;
      meas_lines <= 20'h0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= 14'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      axi_rsp_o <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
      frame_start_o   <= 1'b0;
      line_tick_o     <= 1'b0;
      readout_en_o    <= 1'b0;
      readout_row_o   <= 20'h0;
      shutter_en_o    <= 1'b0;
      shutter_row_o   <= 20'h0;
      horiz_flip_o    <= 1'b0;
      vert_flip_o     <= 1'b0;
      frame_invalid_o <= 1'b0;
      integ_lines_o   <= 20'h0;
      integ_offset_o  <= 8'h0;
    end else begin
      frame_line_count        <= next_frame_line_count;
      shutter_sweep_line      <= next_shutter_sweep_line;
      readout_direction_ctrl  <= next_readout_direction_ctrl;
      total_gain_code         <= next_total_gain_code;
      black_level_offset      <= next_black_level_offset;
      sync_role_select        <= next_sync_role_select;
      conversion_width_select <= next_conversion_width_select;
      act_gain   <= next_act_gain;
      act_black  <= next_act_black;
      act_sweep  <= next_act_sweep;
      act_wide   <= next_act_wide;
      vs_s1 <= vert_sync_pin_b_i;
      vs_s2 <= vs_s1;
      vs_d  <= vs_s2;
      hs_s1 <= horiz_sync_pin_b_i;
      hs_s2 <= hs_s1;
      hs_d  <= hs_s2;
      hcnt       <= next_hcnt;
      line_cnt   <= next_line_cnt;
      meas_lines <= next_meas_lines;
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_idx  <= next_aw_idx;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      axi_rsp_o <= next_rsp;
      frame_start_o   <= next_frame_start;
      line_tick_o     <= next_line_tick;
      readout_en_o    <= next_readout_en;
      readout_row_o   <= next_readout_row;
      shutter_en_o    <= next_shutter_en;
      shutter_row_o   <= next_shutter_row;
      horiz_flip_o    <= next_hflip;
      vert_flip_o     <= next_vflip;
      frame_invalid_o <= next_invalid;
      integ_lines_o   <= next_integ_lines;
      integ_offset_o  <= next_integ_offset;
    end
  end

  // Pixel path runs on the active frame settings
  sgec_pixel_gain u_pixel (
    .clock_i       (clock_i),
    .rst_b_i       (rst_b_i),
    .pix_valid_i   (pix_valid_i),
    .pix_data_i    (pix_data_i),
    .gain_code_i   (act_gain),
    .black_level_i (act_black),
    .wide_i        (act_wide),
    .pix_valid_o   (pix_valid_o),
    .pix_data_o    (pix_data_o)
  );

endmodule : sgec_top

// file: sgec_sync_host.sv
/* Host model: active-low line and frame syncs for slave mode.
   Assumes clock_i shared with the block; idle high. */
`timescale 1ns/10ps
module sgec_sync_host (
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic       run_i,
  input  wire logic [7:0] lines_i,
  output logic            vsync_b_o,
  output logic            hsync_b_o
);
  logic [2:0] cyc;
  logic [7:0] line;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i || !run_i) begin
      cyc  <= 3'h0;
      line <= 8'h00;
    end else begin
      cyc <= cyc + 3'h1;
      if (cyc == 3'h7) begin
        line <= (line == lines_i - 8'h01) ? 8'h00 : line + 8'h01;
      end
    end
  end
  assign hsync_b_o = !(run_i && cyc < 3'h3);
  assign vsync_b_o = !(run_i && line == 8'h00 && cyc >= 3'h4 && cyc < 3'h7);
endmodule : sgec_sync_host

// file: sgec_chk.sv
/* Port checker of sgec_top.
   Assumes the bind below. */
`timescale 1ns/10ps
module sgec_chk (
  input wire logic                    clock_i,
  input wire logic                    rst_b_i,
  input wire sgec_pkg::sgec_axi_req_s axi_req_i,
  input wire sgec_pkg::sgec_axi_rsp_s axi_rsp_o,
  input wire logic                    pix_valid_i,
  input wire logic                    pix_valid_o,
  input wire logic                    frame_start_o,
  input wire logic                    line_tick_o,
  input wire logic                    readout_en_o,
  input wire logic                    shutter_en_o,
  input wire logic                    horiz_flip_o,
  input wire logic                    vert_flip_o,
  input wire logic                    frame_invalid_o,
  input wire logic [19:0]             integ_lines_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_wr_take;
    axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready;
  endsequence
  sequence s_rd_take;
    axi_req_i.arvalid && axi_rsp_o.arready;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##2 axi_rsp_o.bvalid) else $error("no bresp");
  a_rd_answer: assert property (s_rd_take |=> axi_rsp_o.rvalid) else $error("no rdata");
  a_rd_once: assert property (axi_rsp_o.rvalid && axi_req_i.rready |=> !axi_rsp_o.rvalid)
    else $error("read twice");
  a_pix_latency: assert property (pix_valid_i |=> pix_valid_o) else $error("pixel late");
  a_pix_idle: assert property (!pix_valid_i |=> !pix_valid_o) else $error("pixel extra");
  a_frame_pulse: assert property (frame_start_o |=> !frame_start_o) else $error("frame pulse");
  a_read_line: assert property (readout_en_o |-> line_tick_o) else $error("read off line");
  a_shut_line: assert property (shutter_en_o |-> line_tick_o) else $error("reset off line");
  a_flip_framed: assert property ($changed({horiz_flip_o, vert_flip_o}) |->
    frame_start_o || $past(frame_start_o)) else $error("flip off frame");
  a_vflip_invalid: assert property ($changed(vert_flip_o) |-> ##[0:1] frame_invalid_o)
    else $error("no invalid");
  a_integ_framed: assert property ($changed(integ_lines_o) |->
    frame_start_o || $past(frame_start_o)) else $error("integ off frame");
endmodule : sgec_chk
bind sgec_top sgec_chk chk_u (.*);

// file: sgec_top_test.sv
/* Self-checking bench of sgec_top.
   Assumes host model and checker compiled alongside. */
`timescale 1ns/10ps
`include "sgec_defines.svh"
module sgec_top_test;
  logic                    clock_i = 1'b0;
  logic                    rst_b_i = 1'b0;
  sgec_pkg::sgec_axi_req_s req     = '0;
  sgec_pkg::sgec_axi_rsp_s rsp;
  logic                    pv      = 1'b0;
  logic [11:0]             pd      = 12'h000;
  logic                    run     = 1'b0;
  logic                    vs_b, hs_b, pvo, fs, lt, re, hf, vf, finv;
  logic [11:0]             pdo;
  logic [19:0]             il;
  logic [7:0]              io;
  logic [31:0]             d;
  logic [1:0]              r;
  int                      err_total, total_checks, cyc, n, m;
  always #10 clock_i = ~clock_i;
  sgec_top #(.LINE_CYCLES(8), .READ_LINES(16)) dut_u (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .axi_req_i(req), .axi_rsp_o(rsp),
    .vert_sync_pin_b_i(vs_b), .horiz_sync_pin_b_i(hs_b), .pix_valid_i(pv), .pix_data_i(pd),
    .pix_valid_o(pvo), .pix_data_o(pdo), .frame_start_o(fs), .line_tick_o(lt),
    .readout_en_o(re), .readout_row_o(), .shutter_en_o(), .shutter_row_o(),
    .horiz_flip_o(hf), .vert_flip_o(vf), .frame_invalid_o(finv), .integ_lines_o(il),
    .integ_offset_o(io));
  sgec_sync_host host_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .run_i(run),
    .lines_i(8'h0C), .vsync_b_o(vs_b), .hsync_b_o(hs_b));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [13:0] i, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock_i);
    req.awvalid <= 1'b1; req.awaddr <= {i, 2'h0}; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hF; req.bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk("bresp", 32'(er), 32'(rsp.bresp));
  endtask : wr
  task automatic rd(input logic [13:0] i, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock_i);
    req.arvalid <= 1'b1; req.araddr <= {i, 2'h0}; req.rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata; r = rsp.rresp; req.rready <= 1'b0;
  endtask : rd
  task automatic frame;
    do @(posedge clock_i); while (fs !== 1'b1);
  endtask : frame
  task automatic count(output int n, output int m);
    n = 0; m = 0;
    do begin
      n += int'(lt === 1'b1); m += int'(re === 1'b1);
      @(posedge clock_i);
    end while (fs !== 1'b1);
  endtask : count
  task automatic pix(input logic [11:0] x, input logic [11:0] e);
    @(posedge clock_i); pv <= 1'b1; pd <= x;
    @(posedge clock_i); pv <= 1'b0;
    @(posedge clock_i); chk("pix", 32'(e), 32'(pdo)); chk("pv", 1, 32'(pvo));
  endtask : pix
  task automatic t_regs;
    logic [13:0] ix [7] = '{`SGEC_IDX_FRAME_LINES, `SGEC_IDX_DIRECTION, `SGEC_IDX_SWEEP_LINE,
      `SGEC_IDX_GAIN_CODE, `SGEC_IDX_BLACK_LEVEL, `SGEC_IDX_SYNC_ROLE, `SGEC_IDX_CONV_WIDTH};
    logic [31:0] ev [7] = '{32'h008CA, 32'h0, 32'h00066, 32'h0, 32'h032, 32'h0, 32'h1};
    foreach (ix[k]) begin
      rd(ix[k], d, r); chk("reset", ev[k], d);
    end
    rd(14'h0001, d, r); chk("rresp", 32'h2, 32'(r)); chk("rdata", 0, d);
    wr(14'h0001, 32'h5, 2'h2);
  endtask : t_regs
  task automatic t_frame;
    wr(`SGEC_IDX_FRAME_LINES, 32'h14, 2'h0);
    wr(`SGEC_IDX_SWEEP_LINE, 32'h0A, 2'h0);
    frame(); frame(); count(n, m);
    chk("lines", 32'd20, 32'(n));
    chk("rows", 32'd16, 32'(m));
    chk("integ", 32'd10, 32'(il));
    chk("toff", 32'd134, 32'(io));
    rd(`SGEC_IDX_INTEG_LINES, d, r); chk("ireg", 32'd10, d);
  endtask : t_frame
  task automatic t_gain;
    pix(12'h100, 12'h1C8);
    wr(`SGEC_IDX_GAIN_CODE, 32'h14, 2'h0);
    pix(12'h100, 12'h1C8);
    frame(); pix(12'h100, 12'h2C8);
    wr(`SGEC_IDX_GAIN_CODE, 32'h0, 2'h0); wr(`SGEC_IDX_CONV_WIDTH, 32'h0, 2'h0);
    frame(); pix(12'h100, 12'h132);
    chk("toff", 32'd90, 32'(io));
    wr(`SGEC_IDX_GAIN_CODE, 32'hFFFFFFFF, 2'h0);
    rd(`SGEC_IDX_GAIN_CODE, d, r); chk("gain", 32'h1FF, d);
    frame(); pix(12'h0FF, 12'h3FF);
  endtask : t_gain
  task automatic t_flip;
    wr(`SGEC_IDX_DIRECTION, 32'h3, 2'h0);
    frame(); repeat (3) @(posedge clock_i);
    chk("flips", 32'h3, 32'({vf, hf}));
    chk("inval", 1, 32'(finv));
    frame(); repeat (3) @(posedge clock_i);
    chk("inval", 0, 32'(finv));
  endtask : t_flip
  task automatic t_slave;
    wr(`SGEC_IDX_SYNC_ROLE, 32'h1, 2'h0);
    @(posedge clock_i); run <= 1'b1;
    frame(); frame(); count(n, m);
    chk("slines", 32'd12, 32'(n));
    rd(`SGEC_IDX_STATUS, d, r); chk("meas", 32'd12, 32'(d[19:0]));
  endtask : t_slave
  initial begin
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_regs(); t_frame(); t_gain(); t_flip(); t_slave();
    stop_test();
  end
endmodule : sgec_top_test
